//--- core/twg_waveform_generator.sv
/*
 * Waveform generator of a 16-bit timer with three compare channels:
 * frequency, single-slope and dual-slope PWM, split mode, commands, pin override.
 * Assumes configuration, writes and commands come from logic on sys_clk.
 */
`timescale 1ns/10ps

module twg_waveform_generator (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input twg_pkg::twg_cfg_type cfg,
    input twg_pkg::twg_wr_type wr,
    input twg_pkg::twg_cmd_type command,
    input twg_pkg::twg_pin_type pins,
    output logic [15:0] count_value,
    output logic count_down,
    output logic [3:0] buffer_valid,
    output logic [5:0] waveform,
    output logic low_underflow,
    output logic high_underflow,
    output logic [2:0] compare_match,
    output logic [5:0] pin_value,
    output logic [5:0] pin_oe_n
);

    // ==========================================================
    // state
    logic [twg_pkg::TWG_PRESC_W-1:0] presc_reg;
    logic [twg_pkg::TWG_PRESC_W-1:0] presc_mask;
    logic [15:0] per_reg;
    logic [15:0] per_buf_reg;
    logic [15:0] cmp_reg [twg_pkg::TWG_CH];
    logic [15:0] cmp_buf_reg [twg_pkg::TWG_CH];
    logic [3:0] bv_reg;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic dir_reg;
    logic dir_next;
    logic upd_point;
    logic [5:0] wave_reg;
    logic [5:0] wave_next;
    logic [5:0] ovr;
    logic lunf_reg;
    logic hunf_reg;
    logic [2:0] match_reg;
    logic [5:0] pin_value_reg;
    logic [5:0] pin_oe_n_reg;
    logic tick;
    logic [15:0] top;
    logic restart;
    logic hard_reset;
    logic do_update;

    function automatic logic [15:0] merge(input logic [15:0] old, input twg_pkg::twg_wr_type w);
        merge = old;
        if (w.byte_en[0]) begin
            merge[7:0] = w.data[7:0];
        end
        if (w.byte_en[1]) begin
            merge[15:8] = w.data[15:8];
        end
    endfunction

    // ==========================================================
    // commands and prescaler
    assign restart = clk_en && command == twg_pkg::TWG_CMD_RESTART;
    // reset while running is dropped, the timer would lose its period mid-frame
    assign hard_reset = clk_en && command == twg_pkg::TWG_CMD_RESET && !cfg.enable;
    assign do_update = !cfg.split && clk_en && ((command == twg_pkg::TWG_CMD_UPDATE)
        || (tick && upd_point && !cfg.update_lock));
    // divider is a power of two, two to the select value
    assign presc_mask = twg_pkg::TWG_PRESC_W'((8'h01 << cfg.presc_sel) - 8'h01);
    assign tick = clk_en && cfg.enable && ((presc_reg & presc_mask) == presc_mask);
    assign top = (cfg.wave == twg_pkg::TWG_WAVE_FRQ) ? cmp_reg[0] : per_reg;

    always_ff @(posedge sys_clk) begin
        if (rst || hard_reset || restart) begin
            presc_reg <= '0;
        end else if (clk_en) begin
            presc_reg <= cfg.enable ? presc_reg + 1'b1 : '0;
        end
    end

    // ==========================================================
    // count sequence
    always_comb begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        upd_point = 1'b0;
        if (cfg.split) begin
            // two byte timers, down only, each reloads its own period byte
            cnt_next[7:0] = (cnt_reg[7:0] == 8'h00) ? per_reg[7:0] : cnt_reg[7:0] - 8'h01;
            cnt_next[15:8] = (cnt_reg[15:8] == 8'h00) ? per_reg[15:8] : cnt_reg[15:8] - 8'h01;
        end else if (cfg.wave == twg_pkg::TWG_WAVE_DUAL) begin
            if (!dir_reg) begin
                if (cnt_reg >= per_reg) begin
                    dir_next = 1'b1;
                    cnt_next = cnt_reg - 16'h0001;
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end else if (cnt_reg == 16'h0000) begin
                dir_next = 1'b0;
                cnt_next = 16'h0001;
                upd_point = 1'b1;
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end else if (!dir_reg) begin
            if (cnt_reg >= top) begin
                cnt_next = 16'h0000;
                upd_point = 1'b1;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end else if (cnt_reg == 16'h0000) begin
            cnt_next = top;
            upd_point = 1'b1;
        end else begin
            cnt_next = cnt_reg - 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || hard_reset) begin
            cnt_reg <= twg_pkg::TWG_CNT_RST;
        end else if (restart) begin
            cnt_reg <= 16'h0000;
        end else if (clk_en && wr.cnt_wr) begin
            cnt_reg <= merge(cnt_reg, wr);
        end else if (tick) begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || hard_reset || restart) begin
            dir_reg <= 1'b0;
        end else if (clk_en && wr.dir_wr) begin
            dir_reg <= wr.data[0];
        end else if (tick && !cfg.split) begin
            dir_reg <= dir_next;
        end
    end

    // ==========================================================
    // period, compare and buffers; a buffer write beats the update clear
    always_ff @(posedge sys_clk) begin
        if (rst || hard_reset) begin
            per_reg <= twg_pkg::TWG_PER_RST;
            per_buf_reg <= twg_pkg::TWG_BUF_RST;
            bv_reg <= 4'h0;
            for (int i = 0; i < twg_pkg::TWG_CH; i++) begin
                cmp_reg[i] <= twg_pkg::TWG_CMP_RST;
                cmp_buf_reg[i] <= twg_pkg::TWG_BUF_RST;
            end
        end else if (clk_en) begin
            if (wr.per_wr) begin
                per_reg <= merge(per_reg, wr);
            end else if (do_update && bv_reg[3]) begin
                per_reg <= per_buf_reg;
            end
            if (wr.per_buf_wr && !cfg.split) begin
                per_buf_reg <= merge(per_buf_reg, wr);
                bv_reg[3] <= 1'b1;
            end else if (do_update) begin
                bv_reg[3] <= 1'b0;
            end
            for (int i = 0; i < twg_pkg::TWG_CH; i++) begin
                if (wr.cmp_wr[i]) begin
                    cmp_reg[i] <= merge(cmp_reg[i], wr);
                end else if (do_update && bv_reg[i]) begin
                    cmp_reg[i] <= cmp_buf_reg[i];
                end
                if (wr.cmp_buf_wr[i] && !cfg.split) begin
                    cmp_buf_reg[i] <= merge(cmp_buf_reg[i], wr);
                    bv_reg[i] <= 1'b1;
                end else if (do_update) begin
                    bv_reg[i] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // waveform outputs, evaluated on the count seen at each tick
    always_comb begin
        wave_next = wave_reg;
        for (int i = 0; i < twg_pkg::TWG_CH; i++) begin
            if (cfg.split) begin
                if (cnt_reg[7:0] == 8'h00) begin
                    wave_next[i] = 1'b0;
                end else if (cnt_reg[7:0] == cmp_reg[i][7:0]) begin
                    wave_next[i] = 1'b1;
                end
                if (cnt_reg[15:8] == 8'h00) begin
                    wave_next[i+3] = 1'b0;
                end else if (cnt_reg[15:8] == cmp_reg[i][15:8]) begin
                    wave_next[i+3] = 1'b1;
                end
            end else begin
                wave_next[i+3] = 1'b0;
                unique case (cfg.wave)
                    twg_pkg::TWG_WAVE_FRQ: begin
                        // phase against channel zero falls out of where the count stands
                        if (cnt_reg == cmp_reg[i]) begin
                            wave_next[i] = !wave_reg[i];
                        end
                    end
                    twg_pkg::TWG_WAVE_SINGLE: begin
                        // clear wins at bottom so a zero compare stays low
                        if (cnt_reg == cmp_reg[i]) begin
                            wave_next[i] = 1'b0;
                        end else if (cnt_reg == 16'h0000) begin
                            wave_next[i] = 1'b1;
                        end
                    end
                    twg_pkg::TWG_WAVE_DUAL: begin
                        if (cnt_reg == cmp_reg[i]) begin
                            if (cnt_reg == 16'h0000) begin
                                wave_next[i] = 1'b0;
                            end else if (cnt_reg == per_reg) begin
                                wave_next[i] = 1'b1;
                            end else begin
                                wave_next[i] = dir_reg;
                            end
                        end else if (cnt_reg == 16'h0000) begin
                            wave_next[i] = 1'b1;
                        end
                    end
                    twg_pkg::TWG_WAVE_NORMAL: begin
                        wave_next[i] = wave_reg[i];
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || hard_reset || restart) begin
            wave_reg <= 6'h00;
        end else if (tick) begin
            wave_reg <= wave_next;
        end
    end

    // ==========================================================
    // event pulses; a frozen clock enable stretches them
    always_ff @(posedge sys_clk) begin
        if (rst || hard_reset) begin
            lunf_reg <= 1'b0;
            hunf_reg <= 1'b0;
            match_reg <= 3'h0;
        end else if (clk_en) begin
            lunf_reg <= tick && (cfg.split ? cnt_reg[7:0] == 8'h00 : upd_point);
            hunf_reg <= tick && cfg.split && cnt_reg[15:8] == 8'h00;
            for (int i = 0; i < twg_pkg::TWG_CH; i++) begin
                match_reg[i] <= tick && (cfg.split ? cnt_reg[7:0] == cmp_reg[i][7:0]
                    : cnt_reg == cmp_reg[i]);
            end
        end
    end

    // ==========================================================
    // port override
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            ovr[i] = cfg.wave != twg_pkg::TWG_WAVE_NORMAL && cfg.ch_en[i % 3]
                && (i < 3 || cfg.split);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_value_reg <= 6'h00;
            pin_oe_n_reg <= 6'h3f;
        end else if (clk_en) begin
            for (int i = 0; i < 6; i++) begin
                pin_value_reg[i] <= pins.dir[i]
                    && ((ovr[i] ? wave_reg[i] : pins.out_val[i]) ^ pins.invert[i]);
            end
            pin_oe_n_reg <= ~pins.dir;
        end
    end

    assign count_value = cnt_reg;
    assign count_down = dir_reg;
    assign buffer_valid = bv_reg;
    assign waveform = wave_reg;
    assign low_underflow = lunf_reg;
    assign high_underflow = hunf_reg;
    assign compare_match = match_reg;
    assign pin_value = pin_value_reg;
    assign pin_oe_n = pin_oe_n_reg;

    // ==========================================================
    // checks
    property p_frq_toggle;
        @(posedge sys_clk) disable iff (rst)
        tick && !cfg.split && cfg.wave == twg_pkg::TWG_WAVE_FRQ && cnt_reg == cmp_reg[0]
            && command == twg_pkg::TWG_CMD_NONE |=> wave_reg[0] != $past(wave_reg[0]);
    endproperty
    a_frq_toggle: assert property (p_frq_toggle) else $error("frequency output did not toggle");

    property p_ss_set;
        @(posedge sys_clk) disable iff (rst)
        tick && !cfg.split && cfg.wave == twg_pkg::TWG_WAVE_SINGLE && cnt_reg == 16'h0000
            && cmp_reg[0] != 16'h0000 && command == twg_pkg::TWG_CMD_NONE |=> wave_reg[0];
    endproperty
    a_ss_set: assert property (p_ss_set) else $error("single slope output not set at bottom");

    property p_ss_low;
        @(posedge sys_clk) disable iff (rst)
        tick && !cfg.split && cfg.wave == twg_pkg::TWG_WAVE_SINGLE && cnt_reg == 16'h0000
            && cmp_reg[2] == 16'h0000 |=> !wave_reg[2];
    endproperty
    a_ss_low: assert property (p_ss_low) else $error("zero compare did not stay low");

    property p_ds_top;
        @(posedge sys_clk) disable iff (rst)
        tick && !cfg.split && cfg.wave == twg_pkg::TWG_WAVE_DUAL && cnt_reg == per_reg
            && cmp_reg[2] == per_reg && command == twg_pkg::TWG_CMD_NONE |=> wave_reg[2];
    endproperty
    a_ds_top: assert property (p_ds_top) else $error("dual slope top compare not high");

    property p_restart;
        @(posedge sys_clk) disable iff (rst)
        restart |=> cnt_reg == 16'h0000 && !dir_reg && wave_reg == 6'h00;
    endproperty
    a_restart: assert property (p_restart) else $error("restart left state behind");

    property p_override;
        @(posedge sys_clk) disable iff (rst)
        clk_en && pins.dir[0] && !ovr[0]
            |=> pin_value_reg[0] == ($past(pins.out_val[0]) ^ $past(pins.invert[0]));
    endproperty
    a_override: assert property (p_override) else $error("pin not from port value");

    property p_invert;
        @(posedge sys_clk) disable iff (rst)
        clk_en && pins.dir[1] && ovr[1]
            |=> pin_value_reg[1] == ($past(wave_reg[1]) ^ $past(pins.invert[1]));
    endproperty
    a_invert: assert property (p_invert) else $error("pin does not carry waveform");

    property p_split_reload;
        @(posedge sys_clk) disable iff (rst)
        tick && cfg.split && cnt_reg[7:0] == 8'h00 && !wr.cnt_wr
            && command == twg_pkg::TWG_CMD_NONE
            |=> cnt_reg[7:0] == $past(per_reg[7:0]) && lunf_reg;
    endproperty
    a_split_reload: assert property (p_split_reload) else $error("low byte did not reload");

endmodule // twg_waveform_generator

//--- shared/twg_pkg.sv
/*
 * Shared types and constants for the timer waveform generator: reset values,
 * mode and command enumerations, and the write, configuration and pin bundles.
 * Assumes all bundles are produced by logic on the same peripheral clock.
 */
package twg_pkg;

    // ==========================================================
    // widths and reset values
    localparam int TWG_CH = 3;
    localparam int TWG_PRESC_W = 7;
    localparam logic [15:0] TWG_PER_RST = 16'hffff;
    localparam logic [15:0] TWG_CMP_RST = 16'h0000;
    localparam logic [15:0] TWG_CNT_RST = 16'h0000;
    localparam logic [15:0] TWG_BUF_RST = 16'h0000;

    // ==========================================================
    // modes and commands
    typedef enum logic [1:0] {
        TWG_WAVE_NORMAL,
        TWG_WAVE_FRQ,
        TWG_WAVE_SINGLE,
        TWG_WAVE_DUAL
    } twg_wave_type;

    typedef enum logic [1:0] {
        TWG_CMD_NONE,
        TWG_CMD_UPDATE,
        TWG_CMD_RESTART,
        TWG_CMD_RESET
    } twg_cmd_type;

    // ==========================================================
    // bundles
    typedef struct packed {
        logic per_wr;
        logic per_buf_wr;
        logic [2:0] cmp_wr;
        logic [2:0] cmp_buf_wr;
        logic cnt_wr;
        logic dir_wr;
        logic [1:0] byte_en;
        logic [15:0] data;
    } twg_wr_type;

    typedef struct packed {
        logic enable;
        logic split;
        twg_wave_type wave;
        logic [2:0] presc_sel;
        logic [2:0] ch_en;
        logic update_lock;
    } twg_cfg_type;

    typedef struct packed {
        logic [5:0] dir;
        logic [5:0] out_val;
        logic [5:0] invert;
    } twg_pin_type;

endpackage

//--- testbench/test_timer_waveform_generator.sv
/*
 * Self-checking bench for the timer waveform generator and its pads.
 * Assumes one 100 MHz clock; results are measured in clock cycles.
 */
`timescale 1ns/10ps
`define CHECK_EQ(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_timer_waveform_generator;
    typedef struct {int kind; int sel; logic [15:0] exp; string nm;} twg_note_type;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    twg_pkg::twg_cfg_type cfg = '0;
    twg_pkg::twg_wr_type wr = '0;
    twg_pkg::twg_cmd_type command = twg_pkg::TWG_CMD_NONE;
    twg_pkg::twg_pin_type pins = '0;
    logic [15:0] count_value;
    logic count_down;
    logic [3:0] buffer_valid;
    logic [5:0] waveform;
    logic low_underflow;
    logic high_underflow;
    logic [2:0] compare_match;
    logic [5:0] pin_value;
    logic [5:0] pin_oe_n;
    logic [5:0] pad;
    int mismatches = 0;
    int tests_run = 0;
    int seed = 32'h6636;
    twg_note_type notes[$];

    always #5 sys_clk = ~sys_clk;

    twg_waveform_generator dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .cfg(cfg),
        .wr(wr), .command(command), .pins(pins), .count_value(count_value),
        .count_down(count_down), .buffer_valid(buffer_valid), .waveform(waveform),
        .low_underflow(low_underflow), .high_underflow(high_underflow),
        .compare_match(compare_match), .pin_value(pin_value), .pin_oe_n(pin_oe_n));
    twg_pin_pads pads (.sys_clk(sys_clk), .pin_value(pin_value), .pin_oe_n(pin_oe_n),
        .pad(pad));

    // ==========================================================
    // observation helpers
    function automatic logic [15:0] obs(int sel);
        case (sel)
            0: obs = {10'h000, waveform};
            1: obs = {10'h000, pin_value};
            2: obs = {10'h000, pin_oe_n};
            3: obs = count_value;
            4: obs = {15'h0000, count_down};
            5: obs = {12'h000, buffer_valid};
            default: obs = {10'h000, pad & ~pin_oe_n};
        endcase
    endfunction
    function automatic logic bit_of(int sel);
        logic [10:0] all;
        all = {compare_match[2], compare_match[1], compare_match[0], high_underflow,
            low_underflow, waveform};
        return all[sel];
    endfunction
    function automatic logic [5:0] pin_exp(twg_pkg::twg_pin_type p);
        logic [5:0] src;
        src = p.out_val;
        for (int i = 0; i < 3; i++) begin
            // static channel levels: ch0 high, ch1 low, ch2 high
            if (cfg.wave != twg_pkg::TWG_WAVE_NORMAL && cfg.ch_en[i]) src[i] = (i != 1);
        end
        return (src ^ p.invert) & p.dir;
    endfunction
    task automatic wait_level(int sel, logic lvl, output int c);
        c = 0;
        do begin
            @(posedge sys_clk);
            #1;
            c++;
        end while (bit_of(sel) !== lvl && c < 3000);
    endtask

    // ==========================================================
    // result watcher: kind 0 snapshot, 1 high cycles in 32, 2 period, 3 high time
    initial begin : monitor
        twg_note_type n;
        int c1;
        int c2;
        forever begin
            wait (notes.size() > 0);
            n = notes[0];
            c1 = 0;
            c2 = 0;
            if (n.kind == 0) begin
                `CHECK_EQ(n.nm, n.exp, obs(n.sel))
            end else if (n.kind == 1) begin
                repeat (32) begin
                    @(posedge sys_clk);
                    #1;
                    c1 += bit_of(n.sel);
                end
                `CHECK_EQ(n.nm, n.exp, 16'(c1))
            end else begin
                // two full periods are skipped so that a change settles first
                repeat (2) begin
                    wait_level(n.sel, 1'b0, c1);
                    wait_level(n.sel, 1'b1, c1);
                end
                wait_level(n.sel, 1'b0, c1);
                if (n.kind == 2) wait_level(n.sel, 1'b1, c2);
                `CHECK_EQ(n.nm, n.exp, 16'(c1 + c2))
            end
            void'(notes.pop_front());
        end
    end

    // ==========================================================
    // drivers
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic expect_val(int kind, int sel, logic [15:0] e, string nm);
        notes.push_back('{kind, sel, e, nm});
        wait (notes.size() == 0);
    endtask
    task automatic write(int what, logic [15:0] d, logic [1:0] be);
        wr = '0;
        wr.byte_en = be;
        wr.data = d;
        if (what == 0) wr.per_wr = 1'b1;
        else if (what == 1) wr.per_buf_wr = 1'b1;
        else if (what < 5) wr.cmp_wr[what - 2] = 1'b1;
        else wr.cmp_buf_wr[what - 5] = 1'b1;
        tick(1);
        wr = '0;
    endtask
    task automatic issue(twg_pkg::twg_cmd_type c);
        command = c;
        tick(1);
        command = twg_pkg::TWG_CMD_NONE;
    endtask
    // direction is never written, so counting stays upward outside dual slope and split mode
    task automatic setup(twg_pkg::twg_wave_type w, input logic [15:0] p, c0, c1, c2,
        input logic [2:0] ps);
        cfg.wave = w;
        cfg.presc_sel = ps;
        cfg.enable = 1'b1;
        write(0, p, 2'b11);
        write(2, c0, 2'b11);
        write(3, c1, 2'b11);
        write(4, c2, 2'b11);
        issue(twg_pkg::TWG_CMD_RESTART);
    endtask
    task automatic print_verdict();
        $display("checks run %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin : watchdog
        #200000;
        mismatches++;
        print_verdict();
    end

    // ==========================================================
    // scenarios
    initial begin : stimulus
        logic [15:0] p;
        logic [15:0] c;
        tick(4);
        rst = 1'b0;
        expect_val(0, 3, 16'h0000, "count after reset");
        expect_val(0, 2, 16'h003f, "oe_n after reset");
        setup(twg_pkg::TWG_WAVE_FRQ, 16'h00ff, 16'h0000, 16'h0000, 16'h0000, 3'h0);
        expect_val(2, 0, 16'h0002, "frq fastest period");
        setup(twg_pkg::TWG_WAVE_FRQ, 16'hffff, 16'h0009, 16'h0009, 16'h0003, 3'h1);
        expect_val(2, 0, 16'h0028, "frq period ch0");
        expect_val(2, 1, 16'h0028, "frq period ch1");
        expect_val(2, 2, 16'h0028, "frq period ch2");
        setup(twg_pkg::TWG_WAVE_SINGLE, 16'h0007, 16'h0003, 16'h0000, 16'h0008, 3'h0);
        expect_val(2, 0, 16'h0008, "single period");
        expect_val(3, 0, 16'h0003, "single high");
        expect_val(1, 1, 16'h0000, "single cmp zero");
        expect_val(1, 2, 16'h0020, "single cmp above per");
        expect_val(1, 6, 16'h0004, "overflow pulses");
        expect_val(1, 8, 16'h0004, "compare pulses");
        expect_val(1, 9, 16'h0004, "compare one pulses");
        expect_val(1, 10, 16'h0000, "compare two above per");
        issue(twg_pkg::TWG_CMD_RESTART);
        expect_val(0, 3, 16'h0000, "count after restart");
        expect_val(0, 4, 16'h0000, "dir after restart");
        expect_val(0, 0, 16'h0000, "wave after restart");
        clk_en = 1'b0;
        tick(5);
        expect_val(0, 3, 16'h0000, "count frozen by enable");
        clk_en = 1'b1;
        setup(twg_pkg::TWG_WAVE_SINGLE, 16'h0007, 16'h0003, 16'h0000, 16'h0008, 3'h2);
        expect_val(2, 0, 16'h0020, "prescaled period");
        for (int m = 0; m < 6; m++) begin
            p = 16'h0003 + 16'($unsigned($random(seed)) % 13);
            c = 16'h0001 + 16'($unsigned($random(seed)) % (p - 1));
            if (m < 3) begin
                setup(twg_pkg::TWG_WAVE_SINGLE, p, c, 16'h0000, 16'h0000, 3'h0);
                expect_val(2, 0, p + 16'h0001, "single random period");
                expect_val(3, 0, c, "single random high");
            end else begin
                setup(twg_pkg::TWG_WAVE_DUAL, p, c, 16'h0000, 16'h0000, 3'h0);
                expect_val(2, 0, 16'h0002 * p, "dual random period");
                expect_val(3, 0, 16'h0002 * c, "dual random high");
            end
        end
        setup(twg_pkg::TWG_WAVE_DUAL, 16'h0006, 16'h0002, 16'h0000, 16'h0006, 3'h0);
        expect_val(1, 1, 16'h0000, "dual cmp zero");
        expect_val(1, 2, 16'h0020, "dual cmp at per");
        setup(twg_pkg::TWG_WAVE_SINGLE, 16'h0007, 16'h0008, 16'h0000, 16'h0008, 3'h0);
        for (int k = 0; k < 6; k++) begin
            {pins.dir, pins.invert, pins.out_val, cfg.ch_en} = 21'($random(seed));
            cfg.wave = k[0] ? twg_pkg::TWG_WAVE_NORMAL : twg_pkg::TWG_WAVE_SINGLE;
            tick(12);
            expect_val(0, 1, {10'h000, pin_exp(pins)}, "pin level");
            expect_val(0, 2, {10'h000, ~pins.dir}, "pin drive");
            expect_val(0, 6, {10'h000, pin_exp(pins)}, "pad level");
        end
        setup(twg_pkg::TWG_WAVE_SINGLE, 16'h0007, 16'h0003, 16'h0000, 16'h0008, 3'h0);
        cfg.update_lock = 1'b1;
        write(1, 16'h000b, 2'b11);
        tick(20);
        expect_val(0, 5, 16'h0008, "valid held by lock");
        issue(twg_pkg::TWG_CMD_UPDATE);
        tick(2);
        expect_val(0, 5, 16'h0000, "valid after update cmd");
        expect_val(2, 0, 16'h000c, "period after update cmd");
        cfg.update_lock = 1'b0;
        write(1, 16'h0007, 2'b11);
        tick(30);
        expect_val(0, 5, 16'h0000, "valid after natural update");
        expect_val(2, 0, 16'h0008, "period after natural update");
        write(5, 16'h0001, 2'b11);
        issue(twg_pkg::TWG_CMD_RESET);
        expect_val(0, 5, 16'h0001, "reset ignored when running");
        cfg.enable = 1'b0;
        tick(1);
        issue(twg_pkg::TWG_CMD_RESET);
        expect_val(0, 5, 16'h0000, "valid after reset cmd");
        expect_val(0, 0, 16'h0000, "wave after reset cmd");
        cfg.split = 1'b1;
        cfg.wave = twg_pkg::TWG_WAVE_SINGLE;
        write(0, 16'h0307, 2'b11);
        write(2, 16'h0102, 2'b11);
        cfg.enable = 1'b1;
        expect_val(2, 0, 16'h0008, "low byte period");
        expect_val(3, 0, 16'h0002, "low byte high");
        expect_val(2, 3, 16'h0004, "high byte period");
        expect_val(3, 3, 16'h0001, "high byte high");
        expect_val(1, 6, 16'h0004, "low underflows");
        expect_val(1, 7, 16'h0008, "high underflows");
        expect_val(1, 8, 16'h0004, "low byte compares");
        write(5, 16'h0004, 2'b11);
        expect_val(0, 5, 16'h0000, "split buffer unused");
        write(0, 16'h0500, 2'b10);
        expect_val(2, 3, 16'h0006, "high byte write");
        expect_val(2, 0, 16'h0008, "low byte untouched");
        print_verdict();
    end
endmodule // test_timer_waveform_generator

//--- testbench/twg_pin_pads.sv
/*
 * Pad model for the six waveform pins of the timer.
 * Assumes pin levels and drive enables come from the generator on sys_clk.
 */
`timescale 1ns/10ps
module twg_pin_pads (
    input wire logic sys_clk,
    input wire logic [5:0] pin_value,
    input wire logic [5:0] pin_oe_n,
    output logic [5:0] pad
);
    // ==========================================================
    // pad levels
    logic [5:0] last_reg = 6'h00;
    always_ff @(posedge sys_clk) begin
        last_reg <= pad;
    end
    // no pull on these pads: a released pad flips every cycle, never holds
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pad[i] = pin_oe_n[i] ? ~last_reg[i] : pin_value[i];
        end
    end
endmodule // twg_pin_pads
